// ===== src/twm_map.vh
// Constants for the two-wire master sequencer
// How it works
// - The master drives every SCL pulse and makes all starts and stops.
// - A transfer ends with stop or repeated start; repeated start keeps the bus.
// - Transmit: first byte is 7-bit address plus direction bit zero.
// - Receive: address plus direction one, then bytes come in and we acknowledge.
// - Bytes move as eight bits; the receiver's acknowledge bit is sampled.
// - The rate timer sets SCL for 100 kHz, 400 kHz or 1 MHz.
// - Start request with both lines high loads the timer from the 7-bit reload.
// - Lines still high at expiry: pull SDA low, set start-seen status bit 3.
// - Reload after start; next expiry clears start request, stops timer, SCL low.
// - Lines low at start, or SCL low early: set collision flag, go idle.
// - Buffer write during start is dropped and sets write-collision flag.
// - Writes to low five control bits are ignored until start completes.
// - A byte loaded into the shift buffer is sent as all eight bits on SDA.
// - The slave's acknowledge is stored in control bit 6.
// - The port event flag rises when the ninth SCL cycle of a sent byte ends, the eighth of a received one.
// - Stop request bit 2 makes a stop; event raised when it finishes.
// - Event flag on start, stop, restart, ack completion, and foreign start/stop.
// - After a start nothing further happens until the hold time passes.
// - Flags set regardless of any interrupt enable.
`ifndef TWM_MAP_VH
`define TWM_MAP_VH
`define TWM_SEN_BIT     0
`define TWM_RSEN_BIT    1
`define TWM_PEN_BIT     2
`define TWM_RCEN_BIT    3
`define TWM_ACKEN_BIT   4
`define TWM_ACKDT_BIT   5
`define TWM_ACKSTAT_BIT 6
`define TWM_S_BIT       3
`define TWM_P_BIT       4
`define TWM_CTRL_RST    7'h00
`define TWM_RELOAD_RST  7'h00
`endif

// ===== src/rate_timer.v
// Reload-style rate timer producing a one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module rate_timer #(
    parameter W = 7
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         load,
    input  wire         halt,
    input  wire [W-1:0] reload,
    output reg          expire_ff
);
    reg [W:0] cnt_ff;
    reg       run_ff;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff    <= {(W+1){1'b0}};
            run_ff    <= 1'b0;
            expire_ff <= 1'b0;
        end
        else
        begin
            expire_ff <= 1'b0;
            if (halt)
                run_ff <= 1'b0;
            else if (load)
            begin
                cnt_ff <= {1'b0, reload};
                run_ff <= 1'b1;
            end
            else if (run_ff)
            begin
                if (cnt_ff == {(W+1){1'b0}})
                begin
                    expire_ff <= 1'b1;
                    run_ff    <= 1'b0;
                end
                else
                    cnt_ff <= cnt_ff - {{W{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/two_wire_master_sequencer.v
// I2C master sequencer: start, restart, stop, byte shift, acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.vh"
module two_wire_master_sequencer #(
    parameter RW = 7
) (
    input  wire          clk,
    input  wire          rst,
    input  wire [RW-1:0] rate_reload_value,
    input  wire [7:0]    ctrl_wdata,
    input  wire          ctrl_we,
    input  wire [7:0]    buf_wdata,
    input  wire          buf_we,
    input  wire          event_clr,
    input  wire          bcol_clr,
    input  wire          write_collision_flag_clr,
    input  wire          scl_in,
    input  wire          sda_in,
    output wire          scl_out,
    output wire          scl_oe,
    output wire          sda_out,
    output wire          sda_oe,
    output wire [7:0]    second_control_register,
    output wire [7:0]    port_status_register,
    output reg  [7:0]    rx_data_ff,
    output reg           port_event_flag_ff,
    output reg           bus_collision_flag_ff,
    output reg           write_collision_flag_ff
);
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_S1    = 4'h1;
    localparam [3:0] ST_S2    = 4'h2;
    localparam [3:0] ST_R0    = 4'h3;
    localparam [3:0] ST_R1    = 4'h4;
    localparam [3:0] ST_LOW   = 4'h5;
    localparam [3:0] ST_HIGH  = 4'h6;
    localparam [3:0] ST_P0    = 4'h7;
    localparam [3:0] ST_P1    = 4'h8;
    localparam [3:0] ST_P2    = 4'h9;
    localparam [3:0] ST_HOLD  = 4'ha;

    reg [1:0] scl_sync_ff;
    reg [1:0] sda_sync_ff;
    reg       scl_d_ff;
    reg       sda_d_ff;
    reg [3:0] st_ff;
    reg [6:0] ctl_ff;
    reg       start_seen_ff;
    reg       stop_seen_ff;
    reg [7:0] sh_ff;
    reg [3:0] bit_ff;
    reg       rx_ff;
    reg       ackbit_ff;
    reg       scl_low_ff;
    reg       sda_low_ff;
    reg       owned_ff;
    reg       tload;
    reg       thalt;
    wire      texp;

    wire scl_s = scl_sync_ff[1];
    wire sda_s = sda_sync_ff[1];
    // Bus conditions, own or foreign: SDA edge while SCL is high
    wire bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    wire starting  = (st_ff == ST_S1) | (st_ff == ST_S2);

    rate_timer #(
        .W (RW)
    ) u_timer (
        .clk       (clk),
        .rst       (rst),
        .load      (tload),
        .halt      (thalt),
        .reload    (rate_reload_value),
        .expire_ff (texp)
    );

    // Open-drain: drive only low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_low_ff;
    assign sda_oe  = sda_low_ff;
    assign second_control_register = {1'b0, ctl_ff};
    assign port_status_register = {3'h0, stop_seen_ff, start_seen_ff, 3'h0};

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync_ff <= 2'b11;
            sda_sync_ff <= 2'b11;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            scl_d_ff    <= scl_s;
            sda_d_ff    <= sda_s;
        end
    end

    always @*
    begin
        tload = 1'b0;
        thalt = 1'b0;
        if (st_ff == ST_IDLE && ctl_ff[`TWM_SEN_BIT] && scl_s && sda_s)
            tload = 1'b1;
        if (texp && st_ff != ST_IDLE && st_ff != ST_S2 && st_ff != ST_P2
            && st_ff != ST_HOLD)
            tload = 1'b1;
        if (texp && st_ff == ST_S1 && scl_s && sda_s)
            tload = 1'b1;
        if (st_ff == ST_HOLD && (ctl_ff[4:0] != 5'h00 || bit_ff != 4'h0))
            tload = 1'b1;
        if (starting && ~scl_s)
            thalt = 1'b1;
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff                   <= ST_IDLE;
            ctl_ff                  <= `TWM_CTRL_RST;
            start_seen_ff           <= 1'b0;
            stop_seen_ff            <= 1'b0;
            sh_ff                   <= 8'h00;
            bit_ff                  <= 4'h0;
            rx_ff                   <= 1'b0;
            ackbit_ff               <= 1'b0;
            scl_low_ff              <= 1'b0;
            sda_low_ff              <= 1'b0;
            owned_ff                <= 1'b0;
            rx_data_ff              <= 8'h00;
            port_event_flag_ff      <= 1'b0;
            bus_collision_flag_ff   <= 1'b0;
            write_collision_flag_ff <= 1'b0;
        end
        else
        begin
            // Clears first; hardware sets below win in the same cycle
            if (event_clr)
                port_event_flag_ff <= 1'b0;
            if (bcol_clr)
                bus_collision_flag_ff <= 1'b0;
            if (write_collision_flag_clr)
                write_collision_flag_ff <= 1'b0;
            if (ctrl_we)
            begin
                ctl_ff[5] <= ctrl_wdata[5];
                if (!starting)
                    ctl_ff[4:0] <= ctrl_wdata[4:0];
            end
            if (buf_we)
            begin
                if (starting)
                    write_collision_flag_ff <= 1'b1;
                else if (st_ff == ST_HOLD)
                begin
                    sh_ff  <= buf_wdata;
                    bit_ff <= 4'h9;
                    rx_ff  <= 1'b0;
                end
            end
            if (bus_start)
                start_seen_ff <= 1'b1;
            if (bus_stop)
            begin
                stop_seen_ff  <= 1'b1;
                start_seen_ff <= 1'b0;
            end
            if (st_ff == ST_IDLE && !owned_ff && (bus_start || bus_stop))
                port_event_flag_ff <= 1'b1;
            case (st_ff)
            ST_IDLE:
            begin
                if (ctl_ff[`TWM_SEN_BIT])
                begin
                    if (!scl_s && !sda_s)
                    begin
                        bus_collision_flag_ff <= 1'b1;
                        ctl_ff[`TWM_SEN_BIT]  <= 1'b0;
                    end
                    else if (scl_s && sda_s)
                        st_ff <= ST_S1;
                end
            end
            ST_S1:
            begin
                if (!scl_s)
                begin
                    bus_collision_flag_ff <= 1'b1;
                    ctl_ff[`TWM_SEN_BIT]  <= 1'b0;
                    ctl_ff[`TWM_RSEN_BIT] <= 1'b0;
                    sda_low_ff            <= 1'b0;
                    owned_ff              <= 1'b0;
                    st_ff                 <= ST_IDLE;
                end
                else if (texp && sda_s)
                begin
                    sda_low_ff    <= 1'b1;
                    start_seen_ff <= 1'b1;
                    stop_seen_ff  <= 1'b0;
                    owned_ff      <= 1'b1;
                    st_ff         <= ST_S2;
                end
            end
            ST_S2:
            begin
                if (texp)
                begin
                    ctl_ff[`TWM_SEN_BIT]  <= 1'b0;
                    ctl_ff[`TWM_RSEN_BIT] <= 1'b0;
                    scl_low_ff            <= 1'b1;
                    port_event_flag_ff    <= 1'b1;
                    st_ff                 <= ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // SCL held low, SDA kept, waiting for the next command
                if (bit_ff != 4'h0)
                begin
                    sda_low_ff <= ~sh_ff[7];
                    st_ff      <= ST_LOW;
                end
                else if (ctl_ff[`TWM_RSEN_BIT])
                begin
                    sda_low_ff <= 1'b0;
                    st_ff      <= ST_R0;
                end
                else if (ctl_ff[`TWM_PEN_BIT])
                begin
                    sda_low_ff <= 1'b1;
                    st_ff      <= ST_P0;
                end
                else if (ctl_ff[`TWM_RCEN_BIT])
                begin
                    sh_ff      <= 8'h00;
                    bit_ff     <= 4'h9;
                    rx_ff      <= 1'b1;
                    sda_low_ff <= 1'b0;
                    st_ff      <= ST_LOW;
                end
                else if (ctl_ff[`TWM_ACKEN_BIT])
                begin
                    sda_low_ff <= ~ctl_ff[`TWM_ACKDT_BIT];
                    bit_ff     <= 4'h1;
                    ackbit_ff  <= 1'b1;
                    st_ff      <= ST_LOW;
                end
            end
            ST_LOW:
            begin
                if (texp)
                begin
                    scl_low_ff <= 1'b0;
                    st_ff      <= ST_HIGH;
                end
            end
            ST_HIGH:
            begin
                // End of high phase: sample SDA, drive the next bit
                if (texp)
                begin
                    scl_low_ff <= 1'b1;
                    bit_ff     <= bit_ff - 4'h1;
                    if (bit_ff > 4'h2)
                    begin
                        sh_ff      <= {sh_ff[6:0], sda_s};
                        sda_low_ff <= rx_ff ? 1'b0 : ~sh_ff[6];
                        st_ff      <= ST_LOW;
                    end
                    else if (bit_ff == 4'h2)
                    begin
                        if (rx_ff)
                        begin
                            rx_data_ff <= {sh_ff[6:0], sda_s};
                            ctl_ff[`TWM_RCEN_BIT] <= 1'b0;
                            port_event_flag_ff    <= 1'b1;
                            bit_ff                <= 4'h0;
                            st_ff                 <= ST_HOLD;
                        end
                        else
                        begin
                            sda_low_ff <= 1'b0;
                            st_ff      <= ST_LOW;
                        end
                    end
                    else
                    begin
                        if (ackbit_ff)
                            ctl_ff[`TWM_ACKEN_BIT] <= 1'b0;
                        else
                            ctl_ff[`TWM_ACKSTAT_BIT] <= sda_s;
                        ackbit_ff          <= 1'b0;
                        sda_low_ff         <= 1'b0;
                        port_event_flag_ff <= 1'b1;
                        st_ff              <= ST_HOLD;
                    end
                end
            end
            ST_R0:
            begin
                if (texp)
                begin
                    scl_low_ff <= 1'b0;
                    st_ff      <= ST_R1;
                end
            end
            ST_R1:
            begin
                if (texp)
                begin
                    ctl_ff[`TWM_SEN_BIT] <= 1'b1;
                    st_ff                <= ST_S1;
                end
            end
            ST_P0:
            begin
                if (texp)
                begin
                    scl_low_ff <= 1'b0;
                    st_ff      <= ST_P1;
                end
            end
            ST_P1:
            begin
                if (texp)
                begin
                    sda_low_ff <= 1'b0;
                    st_ff      <= ST_P2;
                end
            end
            ST_P2:
            begin
                if (texp)
                begin
                    ctl_ff[`TWM_PEN_BIT] <= 1'b0;
                    port_event_flag_ff   <= 1'b1;
                    owned_ff             <= 1'b0;
                    st_ff                <= ST_IDLE;
                end
            end
            default:
                st_ff <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/twm_seq_asserts.sv
// Port assertions for the two-wire master sequencer
`timescale 1ns/1ps
`default_nettype none
module twm_seq_asserts #(
    parameter RW = 7
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic [RW-1:0] rate_reload_value,
    input wire logic          ctrl_we,
    input wire logic          buf_we,
    input wire logic          event_clr,
    input wire logic          scl_out,
    input wire logic          scl_oe,
    input wire logic          sda_out,
    input wire logic          sda_oe,
    input wire logic [7:0]    second_control_register,
    input wire logic [7:0]    port_status_register,
    input wire logic          port_event_flag_ff,
    input wire logic          bus_collision_flag_ff,
    input wire logic          write_collision_flag_ff
);
    logic       prev_ff;
    logic [7:0] cnt_ff;

    // Cycles the SCL drive has held its level, saturating
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev_ff <= 1'b0;
            cnt_ff  <= 8'hff;
        end
        else
        begin
            prev_ff <= scl_oe;
            cnt_ff  <= (scl_oe != prev_ff) ? 8'h00 :
                       cnt_ff + {7'h00, cnt_ff != 8'hff};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_pins_open_drain: assert property (!scl_out && !sda_out)
        else $error("pin output driven high");
    a_start_seen: assert property ($rose(sda_oe) && !scl_oe &&
        second_control_register[0] |-> ##[0:2] port_status_register[3])
        else $error("start seen bit missing");
    a_start_done: assert property ($fell(second_control_register[0])
        |-> ##[0:1] (sda_oe || bus_collision_flag_ff))
        else $error("start ended without sda low");
    a_start_event: assert property ($fell(second_control_register[0])
        && sda_oe |-> ##[0:2] port_event_flag_ff)
        else $error("no event after start");
    a_collision_idle: assert property ($rose(bus_collision_flag_ff)
        |-> ##[0:2] (!sda_oe && !scl_oe && !second_control_register[0]))
        else $error("collision did not return to idle");
    a_event_sticky: assert property (port_event_flag_ff && !event_clr
        |=> port_event_flag_ff)
        else $error("event flag cleared by itself");
    a_write_collision_flag_set: assert property (buf_we && second_control_register[0]
        |=> write_collision_flag_ff)
        else $error("write collision not flagged");
    a_ctrl_locked: assert property (ctrl_we && second_control_register[0]
        |=> $stable(second_control_register[4:1]))
        else $error("control written during start");
    a_stop_release: assert property ($fell(second_control_register[2])
        |-> ##[0:2] (port_event_flag_ff && !sda_oe && !scl_oe))
        else $error("stop did not release bus");
    a_scl_phase: assert property (scl_oe != prev_ff
        |-> cnt_ff >= {1'b0, rate_reload_value})
        else $error("scl phase too short");
endmodule

bind two_wire_master_sequencer twm_seq_asserts #(.RW(RW)) u_chk (
    .clk(clk), .rst(rst), .rate_reload_value(rate_reload_value),
    .ctrl_we(ctrl_we), .buf_we(buf_we), .event_clr(event_clr),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .second_control_register(second_control_register),
    .port_status_register(port_status_register),
    .port_event_flag_ff(port_event_flag_ff),
    .bus_collision_flag_ff(bus_collision_flag_ff),
    .write_collision_flag_ff(write_collision_flag_ff));
`default_nettype wire

// ===== tb/twm_slave_model.sv
// Behavioural two-wire slave on the far side of the sequencer's pins
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model (
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    input  wire logic       hold_low,
    input  wire logic       nack,
    input  wire logic [7:0] tx_byte,
    output wire logic       scl_line,
    output wire logic       sda_line,
    output var  logic [7:0] got_byte,
    output var  logic       got_ack
);
    logic pull = 1'b0;
    logic rd = 1'b0;
    logic addr_ph = 1'b0;
    int   bits = 0;

    initial
    begin
        got_byte = 8'h00;
        got_ack = 1'b0;
    end
    // Open-drain wires with pull-ups
    assign scl_line = ~(scl_oe | hold_low);
    assign sda_line = ~(sda_oe | pull | hold_low);
    // Start or repeated start opens a new frame
    always @(negedge sda_line)
    begin
        // Let SCL settle so a same-edge SCL fall is not taken as a start
        #1;
        if (scl_line === 1'b1)
        begin
            bits = 0;
            rd = 1'b0;
            addr_ph = 1'b1;
            pull = 1'b0;
        end
    end
    always @(posedge scl_line)
    begin
        if (bits < 8 && !rd)
            got_byte = {got_byte[6:0], sda_line};
        if (bits == 8 && rd)
        begin
            got_ack = sda_line;
            rd = !sda_line;
        end
        bits = bits + 1;
    end
    always @(negedge scl_line)
    begin
        if (bits == 9)
        begin
            bits = 0;
            if (addr_ph)
                rd = got_byte[0];
            addr_ph = 1'b0;
        end
        if (bits == 8)
            pull = !rd & !nack;
        else
            pull = rd & !tx_byte[7 - bits];
    end
endmodule
`default_nettype wire

// ===== tb/two_wire_master_sequencer_tb.sv
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            errors++; \
            $display("wrong value %s exp %h seen %h", nm, e, g); \
        end \
    end
module two_wire_master_sequencer_tb;
    logic       clk, rst, ctrl_we, buf_we, event_clr, bcol_clr, write_collision_flag_clr;
    logic [6:0] rate_reload_value;
    logic [7:0] ctrl_wdata, buf_wdata, rx_data_ff, scr, psr, got_byte;
    logic [7:0] tx_byte, rnd, me, mg;
    logic       scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, got_ack;
    logic       ev, bcol, write_collision_flag, hold_low, nack, ev_seen;
    int         errors, num_checks;
    logic [7:0] exp_q[$];
    int         sel_q[$];

    two_wire_master_sequencer #(.RW(7)) uut (
        .clk(clk), .rst(rst), .rate_reload_value(rate_reload_value),
        .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we), .buf_wdata(buf_wdata),
        .buf_we(buf_we), .event_clr(event_clr), .bcol_clr(bcol_clr),
        .write_collision_flag_clr(write_collision_flag_clr), .scl_in(scl_in), .sda_in(sda_in),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .second_control_register(scr),
        .port_status_register(psr), .rx_data_ff(rx_data_ff),
        .port_event_flag_ff(ev), .bus_collision_flag_ff(bcol),
        .write_collision_flag_ff(write_collision_flag));
    twm_slave_model partner (
        .scl_oe(scl_oe), .sda_oe(sda_oe), .hold_low(hold_low), .nack(nack),
        .tx_byte(tx_byte), .scl_line(scl_in), .sda_line(sda_in),
        .got_byte(got_byte), .got_ack(got_ack));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] pick(input int s);
        case (s)
            1: return psr;
            2: return rx_data_ff;
            3: return got_byte;
            default: return {7'h00, got_ack};
        endcase
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic c, input logic [7:0] v);
        @(negedge clk);
        ctrl_wdata = v;
        buf_wdata = v;
        ctrl_we = c;
        buf_we = !c;
        @(negedge clk);
        ctrl_we = 1'b0;
        buf_we = 1'b0;
    endtask
    task automatic clr(input logic [2:0] m);
        {event_clr, bcol_clr, write_collision_flag_clr} = m;
        @(negedge clk);
        {event_clr, bcol_clr, write_collision_flag_clr} = 3'b000;
        @(negedge clk);
    endtask
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 5000)
        begin
            errors++;
            results();
        end
    endtask
    task automatic op(input logic c, input logic [7:0] v, input int s,
                      input logic [7:0] e);
        sel_q.push_back(s);
        exp_q.push_back(e);
        wr(c, v);
        wait_hi(ev);
        @(negedge clk);
        clr(3'b100);
    endtask

    // Each event rise retires the oldest expected result
    always @(negedge clk)
    begin
        if (ev === 1'b1 && !ev_seen && sel_q.size() > 0)
        begin
            me = exp_q.pop_front();
            mg = pick(sel_q.pop_front());
            `CHK("event result", me, mg)
        end
        ev_seen = (ev === 1'b1);
    end

    initial
    begin
        rst = 1'b1;
        {ctrl_we, buf_we, event_clr, bcol_clr, write_collision_flag_clr, hold_low} = '0;
        {nack, ev_seen} = '0;
        {ctrl_wdata, buf_wdata, tx_byte} = '0;
        errors = 0;
        num_checks = 0;
        rate_reload_value = 7'h08; // Phases of about 80 ns, 160 ns per bit
        rnd = 8'h36;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        `CHK("reset regs", 16'h0000, {scr, psr})
        `CHK("pins", 4'h0, {scl_oe, sda_oe, scl_out, sda_out})
        hold_low = 1'b1;
        wr(1'b1, 8'h01);
        wait_hi(bcol);
        repeat (3) @(negedge clk);
        `CHK("collision", 3'b000, {scr[0], scl_oe, sda_oe})
        hold_low = 1'b0;
        repeat (6) @(negedge clk);
        clr(3'b110);
        `CHK("bcol clear", 1'b0, bcol)
        sel_q.push_back(1);
        exp_q.push_back(8'h08);
        wr(1'b1, 8'h01);
        wr(1'b0, 8'h5a);
        wr(1'b1, 8'h04);
        wait_hi(ev);
        @(negedge clk);
        clr(3'b100);
        `CHK("start end", 6'b000111, {scr[2:0], write_collision_flag, sda_oe, scl_oe})
        clr(3'b001);
        `CHK("write_collision_flag clear", 1'b0, write_collision_flag)
        op(1'b0, 8'ha4, 3, 8'ha4);
        `CHK("ack status", 1'b0, scr[6])
        for (int i = 0; i < 3; i++)
        begin
            rnd = lfsr(rnd);
            nack = (i == 2);
            op(1'b0, rnd, 3, rnd);
            `CHK("ack status", nack, scr[6])
        end
        nack = 1'b0;
        op(1'b1, 8'h02, 1, 8'h08);
        `CHK("bus kept", 2'b11, {scl_oe, sda_oe})
        rnd = lfsr(rnd);
        tx_byte = rnd;
        op(1'b0, 8'ha5, 3, 8'ha5);
        for (int i = 0; i < 2; i++)
        begin
            op(1'b1, 8'h08, 2, tx_byte);
            tx_byte = lfsr(tx_byte);
            op(1'b1, i ? 8'h30 : 8'h10, 5, {7'h00, i[0]});
        end
        op(1'b1, 8'h04, 1, 8'h10);
        `CHK("stop end", 3'b000, {scl_oe, sda_oe, scr[2]})
        results();
    end
endmodule
`default_nettype wire
